// ### rtl/nco_pkg.sv
package nco_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int PHASE_W = 32;
    localparam int INST_W = 28;
    localparam int LUT_W = 20;
    localparam int OFFSET_W = 16;
    localparam int PSK_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] PHASE_INPUT_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] TIMER_LSB_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] TIMER_MSB_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFFSET_STAT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] TIMER_STAT_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] PHASE_STAT_OFS = 8'h18;

    // Control register field positions
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_BIN_BIT = 1;
    localparam int CTRL_SER_BIT = 2;
    localparam int CTRL_TEST_BIT = 3;
    localparam int CTRL_W = 4;

    // Reset values
    localparam logic [OFFSET_W-1:0] PHASE_INPUT_RST = 16'h0000;
    localparam logic [OFFSET_W-1:0] TIMER_HALF_RST = 16'h0000;
    localparam logic [CTRL_W-1:0] CONTROL_RST = 4'h0;
    localparam logic [PHASE_W-1:0] TIMER_INCR_RST = 32'h0000_0000;
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 16'h0000;

    // Sample limits and serial word length
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 16'h7FFF;
    localparam int SERIAL_BITS = 16;
endpackage

// ### rtl/sincos_lookup.sv
`timescale 1ns/1ps
`default_nettype none
module sincos_lookup
    import nco_pkg::*;
(
    input  wire logic                clk_i,      // System clock
    input  wire logic                rst_i,      // Sync reset, high
    input  wire logic                ce_i,       // Clock enable
    input  wire logic [LUT_W-1:0]    addr_i,     // Phase address
    output logic      [SAMPLE_W-1:0] sine_o,     // Registered sine
    output logic      [SAMPLE_W-1:0] cosine_o    // Registered cosine
);
    logic [LUT_W-1:0]    cos_addr;
    logic [SAMPLE_W-1:0] sine_next;
    logic [SAMPLE_W-1:0] cosine_next;

    // Parabolic half-wave shape; exact ROM contents are not modelled
    function automatic logic [SAMPLE_W-1:0] wave(input logic [LUT_W-1:0] a);
        logic [18:0]    x;
        logic [19:0]    rest;
        logic [38:0]    prod;
        logic [16:0]    m17;
        logic [SAMPLE_W-1:0] mag;
        x = a[18:0];
        rest = 20'h80000 - {1'b0, x};
        prod = {20'h00000, x} * {19'h00000, rest};
        m17 = prod[37:21];
        // Clamp keeps 8000H from ever appearing
        mag = (m17 > {1'b0, SAMPLE_MAX}) ? SAMPLE_MAX : m17[15:0];
        wave = a[19] ? (16'h0000 - mag) : mag;
    endfunction

    // Quarter turn ahead gives cosine
    assign cos_addr = addr_i + 20'h40000;

    always_comb begin
        sine_next = wave(addr_i);
        cosine_next = wave(cos_addr);
    end

    // One pipeline stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sine_o <= 16'h0000;
            cosine_o <= 16'h0000;
        end else if (ce_i) begin
            sine_o <= sine_next;
            cosine_o <= cosine_next;
        end
    end
endmodule
`default_nettype wire

// ### rtl/serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module serial_shifter
    import nco_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W
) (
    input  wire logic             clk_i,        // System clock
    input  wire logic             rst_i,        // Sync reset, high
    input  wire logic             ce_i,         // Clock enable
    input  wire logic             load_i,       // Load new word
    input  wire logic [WIDTH-1:0] word_i,       // Parallel word
    output logic                  msb_first_o,  // MSB-first stream
    output logic                  lsb_first_o   // LSB-first stream
);
    logic [WIDTH-1:0] msb_sr_reg;
    logic [WIDTH-1:0] lsb_sr_reg;

    // Two shifters, one per bit order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msb_sr_reg <= '0;
            lsb_sr_reg <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                msb_sr_reg <= word_i;
                lsb_sr_reg <= word_i;
            end else begin
                msb_sr_reg <= {msb_sr_reg[WIDTH-2:0], 1'b0};
                // Arithmetic shift repeats sign once word runs out
                lsb_sr_reg <= {lsb_sr_reg[WIDTH-1], lsb_sr_reg[WIDTH-1:1]};
            end
        end
    end

    assign msb_first_o = msb_sr_reg[WIDTH-1];
    assign lsb_first_o = lsb_sr_reg[0];
endmodule
`default_nettype wire

// ### rtl/nco_phase_offset_and_output.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module nco_phase_offset_and_output
    import nco_pkg::*;
(
    input  wire logic                sys_clk_i,          // 125 MHz clock
    input  wire logic                rst_i,              // Sync reset, high
    input  wire logic                ce_i,               // Clock enable
    input  wire logic [ADDR_W-1:0]   addr_i,             // Register address
    input  wire logic [DATA_W-1:0]   wr_data_i,          // Write data
    input  wire logic                wr_strobe_i,        // Write strobe
    input  wire logic                rd_strobe_i,        // Read strobe
    output logic      [DATA_W-1:0]   rd_data_o,          // Read data
    input  wire logic [PHASE_W-1:0]  accum_phase_i,      // Accumulated phase
    input  wire logic [PSK_W-1:0]    psk_phase_code_i,   // PSK phase code
    input  wire logic                phase_offset_load_n_i, // Offset load, low
    input  wire logic                timer_incr_load_n_i,   // Incr load, low
    input  wire logic                accum_enable_n_i,   // Serial load, low
    output logic                     timer_carry_out_o,  // Timer tick
    output logic                     serial_word_strobe_o, // New word strobe
    output logic      [SAMPLE_W-1:0] sine_out_o,         // Sine bus
    output logic      [SAMPLE_W-1:0] cosine_out_o        // Cosine bus
);
    // Register port state
    logic [OFFSET_W-1:0] phase_input_reg;
    logic [OFFSET_W-1:0] timer_lsb_reg;
    logic [OFFSET_W-1:0] timer_msb_reg;
    logic [CTRL_W-1:0]   control_reg;
    logic                phase_source_select;
    logic                offset_binary_select;
    logic                serial_output_select;
    logic                test_select;

    // Load enables and offset path
    logic                offset_load_n_reg;
    logic                timer_load_n_reg;
    logic [OFFSET_W-1:0] phase_offset_reg;
    logic [OFFSET_W-1:0] phase_offset_next;
    logic [PSK_W-1:0]    psk_top;

    // Timer
    logic [PHASE_W-1:0]  timer_incr_reg;
    logic [PHASE_W-1:0]  timer_acc_reg;
    logic [PHASE_W:0]    timer_sum;
    logic                timer_carry_reg;

    // Phase pipeline
    logic [PHASE_W-1:0]  offset_sum;
    logic [INST_W-1:0]   inst_phase_reg;
    logic [INST_W-1:0]   inst_phase_dly_reg;

    // Lookup and output coding
    logic [SAMPLE_W-1:0] lut_sine;
    logic [SAMPLE_W-1:0] lut_cosine;
    logic [SAMPLE_W-1:0] fmt_sine;
    logic [SAMPLE_W-1:0] fmt_cosine;

    // Serial path
    logic                shift_load;
    logic                word_loaded_reg;
    logic                strobe_reg;
    logic                sine_msb_bit;
    logic                sine_lsb_bit;
    logic                cosine_msb_bit;
    logic                cosine_lsb_bit;

    // Output and read registers
    logic [SAMPLE_W-1:0] sine_reg;
    logic [SAMPLE_W-1:0] sine_next;
    logic [SAMPLE_W-1:0] cosine_reg;
    logic [SAMPLE_W-1:0] cosine_next;
    logic [DATA_W-1:0]   rd_data_reg;
    logic [DATA_W-1:0]   rd_data_next;

    // Control bits decoded once
    assign phase_source_select = control_reg[CTRL_SRC_BIT];
    assign offset_binary_select = control_reg[CTRL_BIN_BIT];
    assign serial_output_select = control_reg[CTRL_SER_BIT];
    assign test_select = control_reg[CTRL_TEST_BIT];

    // Input registers written over the register port
    // Status offsets are read only; writes fall through
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_input_reg <= PHASE_INPUT_RST;
            timer_lsb_reg <= TIMER_HALF_RST;
            timer_msb_reg <= TIMER_HALF_RST;
            control_reg <= CONTROL_RST;
        end else if (ce_i && wr_strobe_i) begin
            unique case (addr_i)
                PHASE_INPUT_OFS: phase_input_reg <= wr_data_i[OFFSET_W-1:0];
                TIMER_LSB_OFS:   timer_lsb_reg <= wr_data_i[OFFSET_W-1:0];
                TIMER_MSB_OFS:   timer_msb_reg <= wr_data_i[OFFSET_W-1:0];
                CONTROL_OFS:     control_reg <= wr_data_i[CTRL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data_next = '0;
        if (rd_strobe_i) begin
            unique case (addr_i)
                PHASE_INPUT_OFS: rd_data_next = {16'h0000, phase_input_reg};
                TIMER_LSB_OFS:   rd_data_next = {16'h0000, timer_lsb_reg};
                TIMER_MSB_OFS:   rd_data_next = {16'h0000, timer_msb_reg};
                CONTROL_OFS:     rd_data_next = {28'h0000000, control_reg};
                OFFSET_STAT_OFS: rd_data_next = {16'h0000, phase_offset_reg};
                TIMER_STAT_OFS:  rd_data_next = timer_incr_reg;
                PHASE_STAT_OFS:  rd_data_next = {4'h0, inst_phase_reg};
                default:         rd_data_next = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    // Cleared otherwise, so no stale word lingers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data_reg <= '0;
        end else if (ce_i) begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Load enables are registered before they steer their targets
    // Costs a cycle of load latency, buys timing margin
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            offset_load_n_reg <= 1'b1;
            timer_load_n_reg <= 1'b1;
        end else if (ce_i) begin
            offset_load_n_reg <= phase_offset_load_n_i;
            timer_load_n_reg <= timer_incr_load_n_i;
        end
    end

    // PSK code to top offset bits; upper codes are not binary
    // order, 100 and 110 swap 270 and 180 degrees
    always_comb begin
        unique case (psk_phase_code_i)
            3'h0: psk_top = 3'h0;  // 0 degrees
            3'h1: psk_top = 3'h1;  // 45 degrees
            3'h2: psk_top = 3'h2;  // 90 degrees
            3'h3: psk_top = 3'h3;  // 135 degrees
            3'h4: psk_top = 3'h6;  // 270 degrees
            3'h5: psk_top = 3'h7;  // 315 degrees
            3'h6: psk_top = 3'h4;  // 180 degrees
            3'h7: psk_top = 3'h5;  // 225 degrees
        endcase
    end

    // Offset source: phase input or mapped PSK code
    always_comb begin
        if (phase_source_select) begin
            phase_offset_next = phase_input_reg;
        end else begin
            phase_offset_next = {psk_top, 13'h0000};
        end
    end

    // Offset register, gated by the registered enable
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_offset_reg <= OFFSET_RST;
        end else if (ce_i && !offset_load_n_reg) begin
            phase_offset_reg <= phase_offset_next;
        end
    end

    // Timer increment register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_incr_reg <= TIMER_INCR_RST;
        end else if (ce_i && !timer_load_n_reg) begin
            timer_incr_reg <= {timer_msb_reg, timer_lsb_reg};
        end
    end

    // Increment value is software's job to choose
    assign timer_sum = {1'b0, timer_acc_reg} + {1'b0, timer_incr_reg};

    // Timer accumulator; carry is registered so the tick is glitch free
    // Wrap is silent; the carry is its only sign
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_acc_reg <= '0;
            timer_carry_reg <= 1'b0;
        end else if (ce_i) begin
            timer_acc_reg <= timer_sum[PHASE_W-1:0];
            timer_carry_reg <= timer_sum[PHASE_W];
        end
    end

    // Offset adds only to the upper half of the phase
    // Carry out of the top is dropped; phase wraps
    assign offset_sum = accum_phase_i + {phase_offset_reg, 16'h0000};

    // Stage 1: instantaneous phase, top 28 bits kept
    // Low 4 bits are lost here for good
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            inst_phase_reg <= '0;
            inst_phase_dly_reg <= '0;
        end else if (ce_i) begin
            inst_phase_reg <= offset_sum[PHASE_W-1:PHASE_W-INST_W];
            // Delay matches the lookup stage so test mode has equal latency
            inst_phase_dly_reg <= inst_phase_reg;
        end
    end

    // Stage 2: lookup on the upper 20 phase bits
    // Shape only approximates a sine
    sincos_lookup u_lookup (
        .clk_i    (sys_clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .addr_i   (inst_phase_reg[INST_W-1:INST_W-LUT_W]),
        .sine_o   (lut_sine),
        .cosine_o (lut_cosine)
    );

    // Offset binary flips only the top bit
    // Zero stays out, as 8000H never leaves the lookup
    assign fmt_sine = {lut_sine[SAMPLE_W-1] ^ offset_binary_select,
                       lut_sine[SAMPLE_W-2:0]};
    assign fmt_cosine = {lut_cosine[SAMPLE_W-1] ^ offset_binary_select,
                         lut_cosine[SAMPLE_W-2:0]};

    // Enable low for one cycle loads a serial word
    // Used live, so the load edge is the enable edge
    assign shift_load = serial_output_select && !accum_enable_n_i;

    serial_shifter #(
        .WIDTH (SAMPLE_W)
    ) u_sine_shift (
        .clk_i       (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .load_i      (shift_load),
        .word_i      (fmt_sine),
        .msb_first_o (sine_msb_bit),
        .lsb_first_o (sine_lsb_bit)
    );

    serial_shifter #(
        .WIDTH (SAMPLE_W)
    ) u_cosine_shift (
        .clk_i       (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .load_i      (shift_load),
        .word_i      (fmt_cosine),
        .msb_first_o (cosine_msb_bit),
        .lsb_first_o (cosine_lsb_bit)
    );

    // Strobe aligns with the output register showing the first bit
    // Two stages: shifter load, then output register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            word_loaded_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else if (ce_i) begin
            word_loaded_reg <= shift_load;
            strobe_reg <= word_loaded_reg;
        end
    end

    // Output mux; test bypass only while serial select is high
    // Parallel mode passes coded samples straight on
    always_comb begin
        sine_next = fmt_sine;
        cosine_next = fmt_cosine;
        if (serial_output_select && test_select) begin
            sine_next = inst_phase_dly_reg[INST_W-1:12];
            cosine_next = {inst_phase_dly_reg[11:0], 4'h0};
        end else if (serial_output_select) begin
            // Unused serial bus bits held at zero
            sine_next = {sine_msb_bit, 14'h0000, sine_lsb_bit};
            cosine_next = {cosine_msb_bit, 14'h0000, cosine_lsb_bit};
        end
    end

    // Stage 3: output register; serial mode adds the shifter stage ahead of it
    // Shared by all modes; latency matches in parallel and test modes
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sine_reg <= 16'h0000;
            cosine_reg <= 16'h0000;
        end else if (ce_i) begin
            sine_reg <= sine_next;
            cosine_reg <= cosine_next;
        end
    end

    // Every output port is a flop
    assign rd_data_o = rd_data_reg;
    assign timer_carry_out_o = timer_carry_reg;
    assign serial_word_strobe_o = strobe_reg;
    assign sine_out_o = sine_reg;
    assign cosine_out_o = cosine_reg;
endmodule
`default_nettype wire

// ### verif/nco_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module nco_checker_properties
    import nco_pkg::*;
(
    input wire logic                sys_clk_i,             // Clock
    input wire logic                rst_i,                 // Reset
    input wire logic [ADDR_W-1:0]   addr_i,                // Address
    input wire logic [DATA_W-1:0]   wr_data_i,             // Write data
    input wire logic                wr_strobe_i,           // Write
    input wire logic                rd_strobe_i,           // Read
    input wire logic [DATA_W-1:0]   rd_data_o,             // Read data
    input wire logic [PHASE_W-1:0]  accum_phase_i,         // Phase
    input wire logic [PSK_W-1:0]    psk_phase_code_i,      // PSK code
    input wire logic                phase_offset_load_n_i, // Offset load
    input wire logic                accum_enable_n_i,      // Serial load
    input wire logic                serial_word_strobe_o,  // Word strobe
    input wire logic [SAMPLE_W-1:0] sine_out_o,            // Sine
    input wire logic [SAMPLE_W-1:0] cosine_out_o           // Cosine
);
    logic [CTRL_W-1:0]   ctrl_reg;
    logic [2:0]          quiet_reg;
    logic [OFFSET_W-1:0] pin_reg;
    logic [OFFSET_W-1:0] off_reg;
    logic                load_reg;
    logic [4:0]          bit_reg;
    logic [PHASE_W-1:0]  inst_w;
    logic                settled;
    logic                ser_m;
    logic                tst_m;
    logic                par_m;
    logic                tail;

    // Control shadow; a mode change needs a few cycles to reach the pins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= '0;
            quiet_reg <= '0;
        end else if (wr_strobe_i && addr_i == CONTROL_OFS) begin
            ctrl_reg <= wr_data_i[CTRL_W-1:0];
            quiet_reg <= '0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    // Phase input shadow
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            pin_reg <= '0;
        else if (wr_strobe_i && addr_i == PHASE_INPUT_OFS)
            pin_reg <= wr_data_i[OFFSET_W-1:0];
    end
    // Offset model: enable registered first, register loads one edge later
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_reg <= 1'b0;
            off_reg <= '0;
        end else begin
            load_reg <= !phase_offset_load_n_i;
            if (load_reg)
                off_reg <= ctrl_reg[0] ? pin_reg : {psk_phase_code_i[2],
                    ^psk_phase_code_i[2:1], psk_phase_code_i[0], 13'h0000};
        end
    end
    // Cycles since the last word strobe, saturating
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            bit_reg <= 5'h1F;
        else if (serial_word_strobe_o)
            bit_reg <= 5'h01;
        else if (bit_reg != 5'h1F)
            bit_reg <= bit_reg + 5'h01;
    end
    assign settled = quiet_reg >= 3'h4;
    assign ser_m = settled && ctrl_reg[CTRL_SER_BIT] && !ctrl_reg[CTRL_TEST_BIT];
    assign tst_m = settled && ctrl_reg[CTRL_SER_BIT] && ctrl_reg[CTRL_TEST_BIT];
    assign par_m = settled && !ctrl_reg[CTRL_SER_BIT];
    assign tail = ser_m && bit_reg >= 5'h10 && !serial_word_strobe_o;
    assign inst_w = accum_phase_i + {off_reg, 16'h0000};

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_word_load;
        ser_m && !accum_enable_n_i;
    endsequence
    sequence s_word_start;
        serial_word_strobe_o ##0 sine_out_o[14:1] == 14'h0000;
    endsequence

    a_offset_readback: assert property (
        rd_strobe_i && addr_i == OFFSET_STAT_OFS
        |=> rd_data_o == {16'h0000, $past(off_reg)})
        else $error("offset register readback differs from model");
    a_strobe_cause: assert property (
        serial_word_strobe_o |-> $past(accum_enable_n_i, 2) == 1'b0)
        else $error("word strobe without a load");
    a_strobe_after_load: assert property (
        s_word_load |-> ##2 s_word_start)
        else $error("serial load gave no word strobe");
    a_serial_bits_quiet: assert property (
        ser_m |-> sine_out_o[14:1] == '0 && cosine_out_o[14:1] == '0)
        else $error("serial mode drives middle bus bits");
    a_msb_zero_fill: assert property (
        tail |-> !sine_out_o[15] && !cosine_out_o[15])
        else $error("MSB stream not zero after word");
    a_lsb_sign_hold: assert property (
        tail |-> $stable(sine_out_o[0]) && $stable(cosine_out_o[0]))
        else $error("LSB stream does not repeat sign");
    a_test_phase_out: assert property (
        tst_m |-> {sine_out_o, cosine_out_o[15:4]} == $past(inst_w[31:4], 3))
        else $error("test readout differs from phase");
    a_test_low_nibble: assert property (
        tst_m |-> cosine_out_o[3:0] == 4'h0)
        else $error("test readout low cosine bits set");
    a_twos_range: assert property (
        par_m && !ctrl_reg[CTRL_BIN_BIT]
        |-> sine_out_o != 16'h8000 && cosine_out_o != 16'h8000)
        else $error("most negative code produced");
    a_offbin_range: assert property (
        par_m && ctrl_reg[CTRL_BIN_BIT]
        |-> sine_out_o != 16'h0000 && cosine_out_o != 16'h0000)
        else $error("offset binary zero code produced");
endmodule
`default_nettype wire

// ### verif/quad_sample_sink.sv
`timescale 1ns/1ps
`default_nettype none
module quad_sample_sink (
    input  wire logic        clk_i,    // Clock
    input  wire logic        rst_i,    // Reset
    input  wire logic        strobe_i, // First bit valid
    input  wire logic        sine_i,   // MSB-first sine bit
    input  wire logic        cosine_i, // MSB-first cosine bit
    output logic      [15:0] sine_o,   // Assembled sine
    output logic      [15:0] cosine_o, // Assembled cosine
    output logic             full_o    // Whole word held
);
    logic [4:0] count_reg;

    // Stops after 16 bits so the zero fill never spoils the word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 5'h00;
            sine_o <= 16'h0000;
            cosine_o <= 16'h0000;
        end else if (strobe_i || (count_reg != 5'h00 && !full_o)) begin
            sine_o <= {sine_o[14:0], sine_i};
            cosine_o <= {cosine_o[14:0], cosine_i};
            count_reg <= strobe_i ? 5'h01 : count_reg + 5'h01;
        end
    end
    assign full_o = count_reg == 5'h10;
endmodule
`default_nettype wire

// ### verif/nco_phase_offset_and_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nco_phase_offset_and_output_tb;
    import nco_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] accum = 32'h0;
    logic [2:0]  psk = 3'h0;
    logic        off_ld_n = 1'b1;
    logic        tim_ld_n = 1'b1;
    logic        en_n = 1'b1;
    logic        timer_carry_out;
    logic        strb;
    logic [15:0] sin;
    logic [15:0] cos;
    logic [15:0] snk_sin;
    logic [15:0] snk_cos;
    int          bad_count = 0;
    int          n_tests = 0;
    int          ticks;
    // Offsets for 0,45,90,135,270,315,180,225 degrees
    localparam logic [15:0] PSK_OFS [8] = '{16'h0000, 16'h2000, 16'h4000,
        16'h6000, 16'hC000, 16'hE000, 16'h8000, 16'hA000};
    localparam logic [31:0] PH [3] = '{32'h0, 32'h4000_0FFF, 32'hC000_0000};
    localparam logic [31:0] EXP [3] = '{32'h0000_7FFF, 32'h7FFF_0000,
        32'h8001_0000};
    localparam logic [15:0] SW = 16'h8001;

    nco_phase_offset_and_output dut (
        .sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr),
        .wr_data_i(wdata), .wr_strobe_i(wr), .rd_strobe_i(rd),
        .rd_data_o(rdata), .accum_phase_i(accum), .psk_phase_code_i(psk),
        .phase_offset_load_n_i(off_ld_n), .timer_incr_load_n_i(tim_ld_n),
        .accum_enable_n_i(en_n), .timer_carry_out_o(timer_carry_out),
        .serial_word_strobe_o(strb), .sine_out_o(sin), .cosine_out_o(cos));
    quad_sample_sink sink (
        .clk_i(clk), .rst_i(rst), .strobe_i(strb), .sine_i(sin[15]),
        .cosine_i(cos[15]), .sine_o(snk_sin), .cosine_o(snk_cos),
        .full_o());

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // One-cycle low pulse: 0 offset load, 1 timer load, 2 serial load
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: off_ld_n <= 1'b0;
            1: tim_ld_n <= 1'b0;
            default: en_n <= 1'b0;
        endcase
        @(posedge clk);
        {off_ld_n, tim_ld_n, en_n} <= 3'h7;
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFFSET_STAT_OFS, 32'h0);
        rd_reg(TIMER_STAT_OFS, 32'h0);
        // Offset follows the phase input only on a load
        wr_reg(PHASE_INPUT_OFS, 32'h0000_1234);
        wr_reg(CONTROL_OFS, 32'h1);
        rd_reg(OFFSET_STAT_OFS, 32'h0);
        pulse(0);
        rd_reg(OFFSET_STAT_OFS, 32'h0000_1234);
        wr_reg(OFFSET_STAT_OFS, 32'h0000_FFFF);
        rd_reg(OFFSET_STAT_OFS, 32'h0000_1234);
        // Every PSK code
        wr_reg(CONTROL_OFS, 32'h0);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            psk <= c[2:0];
            pulse(0);
            rd_reg(OFFSET_STAT_OFS, {16'h0, PSK_OFS[c]});
        end
        // Quarter-turn increment wraps every 4 cycles
        wr_reg(TIMER_LSB_OFS, 32'h0);
        wr_reg(TIMER_MSB_OFS, 32'h0000_4000);
        pulse(1);
        rd_reg(TIMER_STAT_OFS, 32'h4000_0000);
        ticks = 0;
        repeat (40) begin
            @(posedge clk);
            #1 ticks += int'(timer_carry_out);
        end
        chk(ticks, 32'd10);
        // Phase readout in test mode, offset still 225 degrees
        @(posedge clk);
        accum <= 32'h0123_4567;
        wr_reg(CONTROL_OFS, 32'hC);
        repeat (4) @(posedge clk);
        #1 chk({sin, cos}, 32'hA123_4560);
        rd_reg(PHASE_STAT_OFS, 32'h0A12_3456);
        @(posedge clk);
        psk <= 3'h0;
        pulse(0);
        // Parallel samples, both codings
        for (int f = 0; f < 2; f++) begin
            wr_reg(CONTROL_OFS, f ? 32'h2 : 32'h0);
            for (int p = 0; p < 3; p++) begin
                @(posedge clk);
                accum <= PH[p];
                repeat (4) @(posedge clk);
                #1 chk({sin, cos}, EXP[p] ^ (f ? 32'h8000_8000 : 32'h0));
            end
        end
        // Serial word of the 270 degree sample, then the fill bits
        wr_reg(CONTROL_OFS, 32'h4);
        repeat (4) @(posedge clk);
        pulse(2);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            #1 chk(strb, k == 0);
            chk({sin[15], sin[0], cos[15], cos[0]}, {k < 16 ? SW[15 - k] : 1'b0, k < 16 ? SW[k] : SW[15], 2'b00});
        end
        chk({snk_sin, snk_cos}, {SW, 16'h0000});
        test_done();
    end
endmodule

bind nco_phase_offset_and_output nco_checker_properties u_chk (.*);
`default_nettype wire
